// ==== core/sram_host_defines.vh ====
// Timing and width constants for the byte-wide static memory host
`ifndef SRAM_HOST_DEFINES_VH
`define SRAM_HOST_DEFINES_VH

`define CLK_PERIOD_NS 100
`define ADDR_W 20
`define DATA_W 8
`define MEM_WORDS 1048576
// Least times, ns
`define T_CYCLE_NS 55
`define T_WP_NS 40
`define T_DW_NS 25
`define T_AW_NS 50
`define T_OE_NS 35
`define T_HZ_NS 20
`define T_OW_NS 5
`define T_AA_NS 55
// Cycle counts, least times rounded up, at least one
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MIN1(t) ((`CYC_UP(t) < 1) ? 1 : `CYC_UP(t))
`define CNT_W 4
// Pin change to synchroniser output, in cycles
`define SYNC_LAT 4'h4

`endif

// ==== core/sram_sync3.v ====
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sram_sync3 #(
	parameter W = 8
)(
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire [W-1:0] async_i,
	output reg [W-1:0] sync_o
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	genvar i;

	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
			s3_q <= {W{1'b0}};
		end
		else
		begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Output bit changes only when stages two and three agree
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			always @(posedge sys_clk_i)
			begin
				if (sys_rst_i)
					sync_o[i] <= 1'b0;
				else if (s2_q[i] == s3_q[i])
					sync_o[i] <= s3_q[i];
			end
		end
	endgenerate
endmodule

// ==== core/sram_host.v ====
// Host controller driving an asynchronous byte-wide static memory
// Contract
// - Shared data bus; host drives only writes
// - Host keeps write window at least 40 ns
// - Data setup 25 ns, hold 0 ns
// - Address and select 50 ns before end
// - Address set before window, held after
// - Cycles spaced at least 55 ns
// - High-select retention lets other pins float
// - Low-select retention keeps high select solid
// - Deselect before supply drops, 0 ns
`timescale 1ns/1ps
`include "sram_host_defines.vh"
module sram_host #(
	parameter AW = `ADDR_W,
	parameter DW = `DATA_W
)(
	input wire sys_clk_i,
	input wire sys_rst_i,
	// User side
	input wire req_valid_i,
	input wire req_write_i,
	input wire [AW-1:0] req_addr_i,
	input wire [DW-1:0] req_wdata_i,
	output wire req_ready_o,
	output reg rsp_valid_o,
	output reg [DW-1:0] rsp_rdata_o,
	input wire retain_req_i,
	output reg retain_o,
	input wire supply_ok_i,
	// Memory pins
	output reg [AW-1:0] word_address_o,
	output reg select_active_low_n_o,
	output reg select_active_high_o,
	output reg write_strobe_n_o,
	output reg output_enable_n_o,
	input wire [DW-1:0] byte_data_bus_i,
	output reg [DW-1:0] byte_data_bus_o,
	output reg byte_data_bus_oe_o
);
	localparam integer CYC_WP_N = `CYC_MIN1(`T_WP_NS);
	localparam integer CYC_DW_N = `CYC_MIN1(`T_DW_NS);
	localparam integer CYC_AW_N = `CYC_MIN1(`T_AW_NS);
	localparam integer CYC_HZ_N = `CYC_MIN1(`T_HZ_NS);
	localparam integer CYC_RD_N = `CYC_MIN1(`T_AA_NS + `T_OE_NS);
	localparam integer CYC_GAP_N = `CYC_MIN1(`T_CYCLE_NS);
	localparam integer CYC_REC_N = `CYC_MIN1(`T_CYCLE_NS);
	localparam [3:0] CYC_WP = CYC_WP_N[3:0];
	localparam [3:0] CYC_DW = CYC_DW_N[3:0];
	localparam [3:0] CYC_AW = CYC_AW_N[3:0];
	localparam [3:0] CYC_HZ = CYC_HZ_N[3:0];
	localparam [3:0] CYC_RD = CYC_RD_N[3:0];
	localparam [3:0] CYC_GAP = CYC_GAP_N[3:0];
	localparam [3:0] CYC_REC = CYC_REC_N[3:0];

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_WSET = 3'h1;
	localparam [2:0] ST_WPUL = 3'h2;
	localparam [2:0] ST_READ = 3'h3;
	localparam [2:0] ST_GAP = 3'h4;
	localparam [2:0] ST_RET = 3'h5;
	localparam [2:0] ST_REC = 3'h6;

	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [`CNT_W-1:0] cnt_q;
	reg [`CNT_W-1:0] cnt_d;
	wire [DW-1:0] rd_sync;
	wire [0:0] ok_sync;

	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	sram_sync3 #(.W(DW)) u_sync_data (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(byte_data_bus_i),
		.sync_o(rd_sync)
	);

	sram_sync3 #(.W(1)) u_sync_ok (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(supply_ok_i),
		.sync_o(ok_sync)
	);

	assign req_ready_o = (st_q == ST_IDLE) && !retain_req_i;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @*
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			ST_IDLE:
			begin
				cnt_d = {`CNT_W{1'b0}};
				if (retain_req_i)
					st_d = ST_RET;
				else if (req_valid_i)
					st_d = req_write_i ? ST_WSET : ST_READ;
			end
			ST_WSET:
				st_d = ST_WPUL;
			ST_WPUL:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q + 1'b1 >= CYC_WP && cnt_q + 1'b1 >= CYC_DW
					&& cnt_q + 1'b1 >= CYC_AW)
				begin
					cnt_d = {`CNT_W{1'b0}};
					st_d = ST_GAP;
				end
			end
			ST_READ:
			begin
				cnt_d = cnt_q + 1'b1;
				// Extra sync latency covered by sampling late
				if (cnt_q + 1'b1 >= CYC_RD + `SYNC_LAT)
				begin
					cnt_d = {`CNT_W{1'b0}};
					st_d = ST_GAP;
				end
			end
			ST_GAP:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q + 1'b1 >= CYC_GAP && cnt_q + 1'b1 >= CYC_HZ)
				begin
					cnt_d = {`CNT_W{1'b0}};
					st_d = ST_IDLE;
				end
			end
			ST_RET:
			begin
				cnt_d = {`CNT_W{1'b0}};
				if (!retain_req_i && ok_sync[0])
					st_d = ST_REC;
			end
			ST_REC:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q + 1'b1 >= CYC_REC)
				begin
					cnt_d = {`CNT_W{1'b0}};
					st_d = ST_IDLE;
				end
			end
			default:
			begin
				st_d = ST_IDLE;
				cnt_d = {`CNT_W{1'b0}};
			end
		endcase
	end

	// ----------------------------------------
	// State, pins and response registers
	// ----------------------------------------
	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			st_q <= ST_IDLE;
			cnt_q <= {`CNT_W{1'b0}};
			word_address_o <= {AW{1'b0}};
			select_active_low_n_o <= 1'b1;
			select_active_high_o <= 1'b1;
			write_strobe_n_o <= 1'b1;
			output_enable_n_o <= 1'b1;
			byte_data_bus_o <= {DW{1'b0}};
			byte_data_bus_oe_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= {DW{1'b0}};
			retain_o <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rsp_valid_o <= 1'b0;
			if (st_q == ST_IDLE && st_d == ST_WSET)
			begin
				word_address_o <= req_addr_i;
				byte_data_bus_o <= req_wdata_i;
				byte_data_bus_oe_o <= 1'b1;
				select_active_low_n_o <= 1'b0;
				output_enable_n_o <= 1'b1;
			end
			if (st_q == ST_IDLE && st_d == ST_READ)
			begin
				word_address_o <= req_addr_i;
				select_active_low_n_o <= 1'b0;
				output_enable_n_o <= 1'b0;
			end
			if (st_q == ST_WSET)
				write_strobe_n_o <= 1'b0;
			if (st_q == ST_WPUL && st_d == ST_GAP)
			begin
				// Strobe and select rise together; data held this edge
				write_strobe_n_o <= 1'b1;
				select_active_low_n_o <= 1'b1;
			end
			if (st_q == ST_GAP && cnt_q == {`CNT_W{1'b0}})
				byte_data_bus_oe_o <= 1'b0;
			if (st_q == ST_READ && st_d == ST_GAP)
			begin
				rsp_valid_o <= 1'b1;
				rsp_rdata_o <= rd_sync;
				output_enable_n_o <= 1'b1;
				select_active_low_n_o <= 1'b1;
			end
			if (st_q == ST_IDLE && st_d == ST_RET)
			begin
				select_active_high_o <= 1'b0;
				select_active_low_n_o <= 1'b1;
				byte_data_bus_oe_o <= 1'b0;
				retain_o <= 1'b1;
			end
			if (st_q == ST_RET && st_d == ST_REC)
			begin
				select_active_high_o <= 1'b1;
				retain_o <= 1'b0;
			end
		end
	end
endmodule

// ==== tb/sram_model.sv ====
// Behavioural byte-wide static memory facing the host
`timescale 1ns/1ps
module sram_model(
	input wire [19:0] a_i,
	input wire cs_n_i,
	input wire cs_i,
	input wire we_n_i,
	input wire oe_n_i,
	input wire [7:0] din_i,
	output logic [7:0] dq_o
);
	logic [7:0] mem [int];
	logic [7:0] last = 8'h00;
	logic wr_q = 1'b0;
	wire sel = !cs_n_i && cs_i;
	wire wr = sel && !we_n_i;
	wire rd = sel && we_n_i && !oe_n_i;
	wire rd_q;
	wire [19:0] a_dly;
	assign #35 rd_q = rd;
	assign #10 a_dly = a_i;
	always @(wr)
	begin
		if (wr_q === 1'b1 && wr === 1'b0)
			mem[a_i] = din_i;
		wr_q = wr;
	end
	always @(rd, rd_q, a_dly)
		if (rd === 1'b1 && rd_q === 1'b1)
		begin
			dq_o = mem.exists(a_dly) ? mem[a_dly] : 8'h00;
			last = dq_o;
		end
		else
			dq_o = ~last;
endmodule

// ==== tb/sram_host_sva.sv ====
// Pin-level checks on the static memory host
`timescale 1ns/1ps
module sram_host_sva #(
	parameter AW = 20,
	parameter DW = 8
)(
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire req_valid_i,
	input wire req_write_i,
	input wire req_ready_o,
	input wire rsp_valid_o,
	input wire retain_o,
	input wire [AW-1:0] word_address_o,
	input wire select_active_low_n_o,
	input wire select_active_high_o,
	input wire write_strobe_n_o,
	input wire output_enable_n_o,
	input wire [DW-1:0] byte_data_bus_o,
	input wire byte_data_bus_oe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	bus_owner_a: assert property (byte_data_bus_oe_o |-> output_enable_n_o)
		else $error("host drives bus while output enable low");
	wr_overlap_a: assert property (!write_strobe_n_o |->
		!select_active_low_n_o && select_active_high_o && byte_data_bus_oe_o)
		else $error("write strobe low outside select");
	wr_stable_a: assert property (!write_strobe_n_o |->
		$stable(word_address_o) && $stable(byte_data_bus_o))
		else $error("address or data moved in write window");
	wr_setup_a: assert property ($fell(write_strobe_n_o) |->
		$past(!select_active_low_n_o) && $stable(word_address_o))
		else $error("select or address late for write");
	data_hold_a: assert property ($rose(write_strobe_n_o) |->
		byte_data_bus_oe_o && $stable(byte_data_bus_o))
		else $error("write data not held at window end");
	rd_answer_a: assert property (req_valid_i && req_ready_o &&
		!req_write_i |-> ##[2:13] rsp_valid_o)
		else $error("read answer late");
	cyc_gap_a: assert property ($rose(select_active_low_n_o) |=>
		select_active_low_n_o)
		else $error("no deselect gap between cycles");
	retain_pins_a: assert property (retain_o |->
		!select_active_high_o && write_strobe_n_o)
		else $error("retention pins wrong");
	idle_standby_a: assert property (req_ready_o |->
		select_active_low_n_o && write_strobe_n_o)
		else $error("idle host not in standby");
	rec_wait_a: assert property ($fell(retain_o) |->
		!req_ready_o)
		else $error("access allowed right after retention");
	cover property ($fell(write_strobe_n_o));
	cover property ($fell(retain_o));
	cover property (rsp_valid_o);
	cover property ($rose(retain_o));
endmodule
bind sram_host sram_host_sva #(.AW(AW), .DW(DW)) i_sram_host_sva (.*);

// ==== tb/testbench.sv ====
// Self-checking bench for the static memory host
`timescale 1ns/1ps
module testbench;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [19:0] req_addr_i = 20'h00000;
	logic [7:0] req_wdata_i = 8'h00;
	logic retain_req_i = 1'b0;
	logic supply_ok_i = 1'b1;
	wire req_ready_o, rsp_valid_o, retain_o, select_active_low_n_o;
	wire select_active_high_o, write_strobe_n_o, output_enable_n_o;
	wire byte_data_bus_oe_o;
	wire [7:0] rsp_rdata_o, byte_data_bus_o, dq;
	wire [19:0] word_address_o;
	wire [7:0] byte_data_bus_i = byte_data_bus_oe_o ? byte_data_bus_o : dq;
	int num_errors = 0;
	int compares = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	sram_host i_sram_host (.*);
	sram_model i_sram_model (.a_i(word_address_o),
		.cs_n_i(select_active_low_n_o), .cs_i(select_active_high_o),
		.we_n_i(write_strobe_n_o), .oe_n_i(output_enable_n_o),
		.din_i(byte_data_bus_i), .dq_o(dq));
	task end_of_test;
		begin
			$display("errors %0d compares %0d", num_errors, compares);
			if (num_errors == 0 && compares > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input string s, input logic [19:0] e, input logic [19:0] g);
		begin
			compares++;
			if (g !== e)
			begin
				num_errors++;
				$display("unexpected %s exp %h got %h", s, e, g);
			end
		end
	endtask
	task tick(inout int n);
		begin
			@(negedge sys_clk_i);
			n++;
			if (n > 40)
			begin
				num_errors++;
				end_of_test;
			end
		end
	endtask
	task acc(input logic w, input logic [19:0] a, input logic [7:0] d);
		int n;
		begin
			n = 0;
			@(posedge sys_clk_i);
			req_valid_i <= 1'b1;
			req_write_i <= w;
			req_addr_i <= a;
			req_wdata_i <= d;
			do tick(n); while (req_ready_o !== 1'b1);
			@(posedge sys_clk_i);
			req_valid_i <= 1'b0;
			if (!w)
				do tick(n); while (rsp_valid_o !== 1'b1);
		end
	endtask
	task t_reset;
		begin
			chk("sel_n", 1, select_active_low_n_o);
			chk("bus_oe", 0, byte_data_bus_oe_o);
		end
	endtask
	task t_rw;
		begin
			acc(1, 20'h00000, 8'hA5);
			acc(1, 20'hFFFFF, 8'h3C);
			acc(1, 20'h00000, 8'h5A);
			acc(0, 20'h00000, 8'h00);
			chk("rd_low", 8'h5A, rsp_rdata_o);
			acc(0, 20'hFFFFF, 8'h00);
			chk("rd_top", 8'h3C, rsp_rdata_o);
		end
	endtask
	task t_retain;
		int n;
		begin
			n = 0;
			@(posedge sys_clk_i);
			retain_req_i <= 1'b1;
			do tick(n); while (retain_o !== 1'b1);
			chk("sel_hi", 0, select_active_high_o);
			chk("ready", 0, req_ready_o);
			@(posedge sys_clk_i);
			supply_ok_i <= 1'b0;
			repeat (6) @(posedge sys_clk_i);
			retain_req_i <= 1'b0;
			repeat (6) @(negedge sys_clk_i);
			chk("held", 1, retain_o);
			@(posedge sys_clk_i);
			supply_ok_i <= 1'b1;
			@(negedge sys_clk_i);
			chk("rec_wait", 1, retain_o);
			acc(0, 20'hFFFFF, 8'h00);
			chk("rd_kept", 8'h3C, rsp_rdata_o);
		end
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		t_reset;
		t_rw;
		t_retain;
		end_of_test;
	end
endmodule
